//--- src/tpm_pkg.sv
// Package of constants and types for the three-phase motor PWM generator
// Function
// - Reset-sync mode makes three common-edge PWM phases
// - Reset-sync drives six pins, ch3 counts up
// - Ch3 drives phase 1, ch4 phases 2, 3
// - Upper limit sets ch3 count cycle
// - Each compare sets its phase pair turning point
// - Period match clears counter, restarts from zero
// - Outputs toggle on compare match and clear
// - Complementary mode gives non-overlapping phases, optionally none
// - Optional period-synchronous toggle on period pin
// - Both counters count up/down in complementary mode
// - Ch3 starts counting from dead time value
// - Upper limit holds half carrier plus dead
// - Ch4 starts from zero counting up
// - Cycle data limits ch4, cycle buffer buffers
// - Dead time sets offset between both counters
// - Three compare registers serve phases 1-3
// - Buffers always CPU readable and writable
// - Hidden temporary registers between buffer and compare
// - Read-only dead-time subcounter provided
// - Access enable bit guards protected registers
// - Ch3 turns down at limit, up at dead
// - Ch4 turns down at cycle, up at zero
// - Compare match drives selected output levels
// - Mode entry copies five buffers: three to compares, two to limits
package tpm_pkg;

    localparam int          CNT_W     = 16;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int          PHASES    = 3;

    typedef enum logic [1:0] {
        TPM_MODE_OFF,
        TPM_MODE_RSYNC,
        TPM_MODE_COMPL
    } tpm_mode_t;

    typedef enum logic [3:0] {
        TPM_SEL_CH3_CNT,
        TPM_SEL_CH4_CNT,
        TPM_SEL_UPLIM,
        TPM_SEL_UPLIM_BUF,
        TPM_SEL_PH1_CMP,
        TPM_SEL_PH2_CMP,
        TPM_SEL_PH3_CMP,
        TPM_SEL_PH1_BUF,
        TPM_SEL_PH2_BUF,
        TPM_SEL_PH3_BUF,
        TPM_SEL_DEAD,
        TPM_SEL_CYC,
        TPM_SEL_CYC_BUF,
        TPM_SEL_SUB
    } tpm_reg_sel_t;

    typedef struct packed {
        logic                writeEn;
        tpm_reg_sel_t        sel;
        logic [CNT_W-1:0]    data;
    } tpm_cpu_req_t;

    typedef struct packed {
        logic phase1Pos;
        logic phase1Neg;
        logic phase2Pos;
        logic phase2Neg;
        logic phase3Pos;
        logic phase3Neg;
    } tpm_pwm_pins_t;

    typedef struct packed {
        logic [CNT_W-1:0]             ch3Counter;
        logic [CNT_W-1:0]             ch4Counter;
        logic [CNT_W-1:0]             ch3UpperLimit;
        logic [CNT_W-1:0]             upperLimitBuffer;
        logic [PHASES-1:0][CNT_W-1:0] phaseCompare;
        logic [PHASES-1:0][CNT_W-1:0] phaseBuffer;
        logic [PHASES-1:0][CNT_W-1:0] phaseTemp;
        logic [CNT_W-1:0]             deadTimeData;
        logic [CNT_W-1:0]             cycleData;
        logic [CNT_W-1:0]             cycleBuffer;
        logic [CNT_W-1:0]             deadTimeSubcounter;
        logic                         countDown;
        tpm_mode_t                    prevMode;
        logic                         periodToggle;
        logic [CNT_W-1:0]             readData;
    } tpm_state_t;

    typedef struct packed {
        logic toggle;
        logic posPin;
        logic negPin;
    } tpm_phase_state_t;

endpackage

//--- src/tpm_phase_out.sv
// One PWM phase: positive and negative pin generation for both modes
`timescale 1ns/1ps
`default_nettype none
module tpm_phase_out
    import tpm_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             rsyncRun,
    input  wire logic             complMode,
    input  wire logic             compareMatch,
    input  wire logic             counterClear,
    input  wire logic [CNT_W-1:0] ch3Count,
    input  wire logic [CNT_W-1:0] ch4Count,
    input  wire logic [CNT_W-1:0] compare,
    input  wire logic             posLevel,
    input  wire logic             negLevel,
    output logic                  posPin,
    output logic                  negPin
);

    tpm_phase_state_t stateReg;
    tpm_phase_state_t stateNext;
    logic             posActive;
    logic             negActive;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        stateNext = stateReg;
        // Ch4 lags ch3 by the dead time, so both can never be active together
        posActive = ch4Count > compare;
        negActive = ch3Count < compare;
        if (rsyncRun) begin
            if (compareMatch || counterClear) begin
                stateNext.toggle = ~stateReg.toggle;
            end
            stateNext.posPin = stateNext.toggle ? posLevel : ~posLevel;
            stateNext.negPin = stateNext.toggle ? ~negLevel : negLevel;
        end else if (complMode) begin
            stateNext.toggle = 1'b0;
            stateNext.posPin = posActive ? posLevel : ~posLevel;
            stateNext.negPin = negActive ? negLevel : ~negLevel;
        end else begin
            stateNext.toggle = 1'b0;
            stateNext.posPin = ~posLevel;
            stateNext.negPin = ~negLevel;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign posPin = stateReg.posPin;
    assign negPin = stateReg.negPin;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    rsync_toggle_a: assert property (
        rsyncRun && (compareMatch || counterClear) && $past(rsyncRun)
        |=> posPin != $past(posPin))
        else $error("phase did not toggle on match or clear");

    compl_level_a: assert property (
        complMode && (ch4Count > compare)
        |=> posPin == $past(posLevel) && negPin != $past(negLevel))
        else $error("complementary level wrong while positive active");

endmodule
`default_nettype wire

//--- src/tpm_three_phase_pwm.sv
// Three-phase motor PWM generator: counters, register set and six outputs
`timescale 1ns/1ps
`default_nettype none
module tpm_three_phase_pwm
    import tpm_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire tpm_mode_t        modeSel,
    input  wire logic             countStart,
    input  wire logic             accessEnableBit,
    input  wire logic             posLevelSelect,
    input  wire logic             negLevelSelect,
    input  wire logic             periodToggleEn,
    input  wire tpm_cpu_req_t     cpuReq,
    output logic [CNT_W-1:0]      cpuRdData,
    output tpm_pwm_pins_t         pwmPins,
    output logic                  pwmOe,
    output logic                  periodTogglePin,
    output logic                  periodToggleOe
);

    tpm_state_t              stateReg;
    tpm_state_t              stateNext;
    logic                    rsyncMode;
    logic                    complMode;
    logic                    rsyncRun;
    logic                    complRun;
    logic                    enterCompl;
    logic                    periodMatch;
    logic                    crestTurn;
    logic                    troughTurn;
    logic                    crestWindow;
    logic                    troughWindow;
    logic [PHASES-1:0]       phaseMatch;
    logic [PHASES-1:0]       phasePos;
    logic [PHASES-1:0]       phaseNeg;

    ////////////////////////////////////////////////////////////////////////////
    // Registers gated by the access enable bit
    function automatic logic isProtected(input tpm_reg_sel_t sel);
        unique case (sel)
            TPM_SEL_CH3_CNT, TPM_SEL_CH4_CNT, TPM_SEL_UPLIM,
            TPM_SEL_PH1_CMP, TPM_SEL_PH2_CMP, TPM_SEL_PH3_CMP,
            TPM_SEL_DEAD, TPM_SEL_CYC: isProtected = 1'b1;
            default:                   isProtected = 1'b0;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] readSel(input tpm_state_t s,
                                                  input tpm_reg_sel_t sel);
        unique case (sel)
            TPM_SEL_CH3_CNT:   readSel = s.ch3Counter;
            TPM_SEL_CH4_CNT:   readSel = s.ch4Counter;
            TPM_SEL_UPLIM:     readSel = s.ch3UpperLimit;
            TPM_SEL_UPLIM_BUF: readSel = s.upperLimitBuffer;
            TPM_SEL_PH1_CMP:   readSel = s.phaseCompare[0];
            TPM_SEL_PH2_CMP:   readSel = s.phaseCompare[1];
            TPM_SEL_PH3_CMP:   readSel = s.phaseCompare[2];
            TPM_SEL_PH1_BUF:   readSel = s.phaseBuffer[0];
            TPM_SEL_PH2_BUF:   readSel = s.phaseBuffer[1];
            TPM_SEL_PH3_BUF:   readSel = s.phaseBuffer[2];
            TPM_SEL_DEAD:      readSel = s.deadTimeData;
            TPM_SEL_CYC:       readSel = s.cycleData;
            TPM_SEL_CYC_BUF:   readSel = s.cycleBuffer;
            TPM_SEL_SUB:       readSel = s.deadTimeSubcounter;
            default:           readSel = CNT_ZERO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign rsyncMode    = modeSel == TPM_MODE_RSYNC;
    assign complMode    = modeSel == TPM_MODE_COMPL;
    assign rsyncRun     = rsyncMode && countStart;
    assign complRun     = complMode && countStart;
    assign enterCompl   = complMode && (stateReg.prevMode != TPM_MODE_COMPL);
    assign periodMatch  = stateReg.ch3Counter == stateReg.ch3UpperLimit;
    assign crestTurn    = complRun && !stateReg.countDown &&
                          ((stateReg.ch4Counter == stateReg.cycleData) || periodMatch);
    assign troughTurn   = complRun && stateReg.countDown &&
                          ((stateReg.ch4Counter == CNT_ZERO) ||
                           (stateReg.ch3Counter == stateReg.deadTimeData));
    assign crestWindow  = stateReg.ch3Counter > stateReg.cycleData;
    assign troughWindow = stateReg.ch4Counter < stateReg.deadTimeData;

    // Phase 1 follows ch3, phases 2 and 3 follow ch4
    assign phaseMatch[0] = stateReg.ch3Counter == stateReg.phaseCompare[0];
    assign phaseMatch[1] = stateReg.ch4Counter == stateReg.phaseCompare[1];
    assign phaseMatch[2] = stateReg.ch4Counter == stateReg.phaseCompare[2];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        stateNext          = stateReg;
        stateNext.prevMode = modeSel;
        if (rsyncRun) begin
            // Software is expected to have zeroed both counters first
            if (periodMatch) begin
                stateNext.ch3Counter = CNT_ZERO;
                stateNext.ch4Counter = CNT_ZERO;
            end else begin
                stateNext.ch3Counter = stateReg.ch3Counter + CNT_ONE;
                stateNext.ch4Counter = stateReg.ch4Counter + CNT_ONE;
            end
        end else if (complMode && !countStart) begin
            stateNext.ch3Counter = stateReg.deadTimeData;
            stateNext.ch4Counter = CNT_ZERO;
            stateNext.countDown  = 1'b0;
        end else if (complRun) begin
            if (crestTurn) begin
                stateNext.countDown = 1'b1;
            end else if (troughTurn) begin
                stateNext.countDown = 1'b0;
            end
            if (stateNext.countDown) begin
                stateNext.ch3Counter = stateReg.ch3Counter - CNT_ONE;
                stateNext.ch4Counter = stateReg.ch4Counter - CNT_ONE;
            end else begin
                stateNext.ch3Counter = stateReg.ch3Counter + CNT_ONE;
                stateNext.ch4Counter = stateReg.ch4Counter + CNT_ONE;
            end
        end
        // Subcounter tracks the counter that spans the dead-time window
        if (complRun) begin
            stateNext.deadTimeSubcounter = crestWindow ? stateReg.ch3Counter
                                                       : stateReg.ch4Counter;
        end
        // Temporaries follow buffers outside the windows, freeze inside
        if (complMode && !(crestWindow || troughWindow)) begin
            stateNext.phaseTemp = stateReg.phaseBuffer;
        end
        if (troughTurn) begin
            stateNext.phaseCompare  = stateReg.phaseTemp;
            stateNext.ch3UpperLimit = stateReg.upperLimitBuffer;
            stateNext.cycleData     = stateReg.cycleBuffer;
        end
        if (crestTurn || troughTurn) begin
            stateNext.periodToggle = ~stateReg.periodToggle;
        end
        if (enterCompl) begin
            stateNext.phaseCompare  = stateReg.phaseBuffer;
            stateNext.phaseTemp     = stateReg.phaseBuffer;
            stateNext.ch3UpperLimit = stateReg.upperLimitBuffer;
            stateNext.cycleData     = stateReg.cycleBuffer;
        end
        // CPU write wins over hardware update in the same cycle
        if (cpuReq.writeEn && (accessEnableBit || !isProtected(cpuReq.sel))) begin
            unique case (cpuReq.sel)
                TPM_SEL_CH3_CNT:   stateNext.ch3Counter       = cpuReq.data;
                TPM_SEL_CH4_CNT:   stateNext.ch4Counter       = cpuReq.data;
                TPM_SEL_UPLIM:     stateNext.ch3UpperLimit    = cpuReq.data;
                TPM_SEL_UPLIM_BUF: stateNext.upperLimitBuffer = cpuReq.data;
                TPM_SEL_PH1_CMP:   stateNext.phaseCompare[0]  = cpuReq.data;
                TPM_SEL_PH2_CMP:   stateNext.phaseCompare[1]  = cpuReq.data;
                TPM_SEL_PH3_CMP:   stateNext.phaseCompare[2]  = cpuReq.data;
                TPM_SEL_PH1_BUF:   stateNext.phaseBuffer[0]   = cpuReq.data;
                TPM_SEL_PH2_BUF:   stateNext.phaseBuffer[1]   = cpuReq.data;
                TPM_SEL_PH3_BUF:   stateNext.phaseBuffer[2]   = cpuReq.data;
                TPM_SEL_DEAD:      stateNext.deadTimeData     = cpuReq.data;
                TPM_SEL_CYC:       stateNext.cycleData        = cpuReq.data;
                TPM_SEL_CYC_BUF:   stateNext.cycleBuffer      = cpuReq.data;
                default:           stateNext.readData         = stateNext.readData;
            endcase
        end
        // Protected registers read as zero while access is blocked
        if (isProtected(cpuReq.sel) && !accessEnableBit) begin
            stateNext.readData = CNT_ZERO;
        end else begin
            stateNext.readData = readSel(stateReg, cpuReq.sel);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stateReg          <= '0;
            stateReg.prevMode <= TPM_MODE_OFF;
        end else begin
            stateReg <= stateNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < PHASES; i++) begin : g_phase
        tpm_phase_out u_phase (
            .sys_clk      (sys_clk),
            .rst          (rst),
            .rsyncRun     (rsyncRun),
            .complMode    (complMode),
            .compareMatch (phaseMatch[i]),
            .counterClear (rsyncRun && periodMatch),
            .ch3Count     (stateReg.ch3Counter),
            .ch4Count     (stateReg.ch4Counter),
            .compare      (stateReg.phaseCompare[i]),
            .posLevel     (posLevelSelect),
            .negLevel     (negLevelSelect),
            .posPin       (phasePos[i]),
            .negPin       (phaseNeg[i])
        );
    end

    assign pwmPins.phase1Pos = phasePos[0];
    assign pwmPins.phase1Neg = phaseNeg[0];
    assign pwmPins.phase2Pos = phasePos[1];
    assign pwmPins.phase2Neg = phaseNeg[1];
    assign pwmPins.phase3Pos = phasePos[2];
    assign pwmPins.phase3Neg = phaseNeg[2];
    assign pwmOe             = rsyncMode || complMode;
    assign periodTogglePin   = stateReg.periodToggle;
    assign periodToggleOe    = complMode && periodToggleEn;
    assign cpuRdData         = stateReg.readData;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_crestReached;
        complRun && !stateReg.countDown && !cpuReq.writeEn &&
        (stateReg.ch4Counter == stateReg.cycleData);
    endsequence

    sequence s_troughReached;
        complRun && stateReg.countDown && !cpuReq.writeEn &&
        (stateReg.ch4Counter == CNT_ZERO);
    endsequence

    rsync_clear_a: assert property (
        rsyncRun && periodMatch && !cpuReq.writeEn
        |=> stateReg.ch3Counter == CNT_ZERO && stateReg.ch4Counter == CNT_ZERO)
        else $error("counter not cleared on period match");

    rsync_upcount_a: assert property (
        rsyncRun && !periodMatch && !cpuReq.writeEn
        |=> stateReg.ch3Counter == $past(stateReg.ch3Counter) + CNT_ONE)
        else $error("reset-sync counter did not increment");

    compl_init_a: assert property (
        complMode && !countStart && !cpuReq.writeEn
        |=> stateReg.ch3Counter == $past(stateReg.deadTimeData)
            && stateReg.ch4Counter == CNT_ZERO)
        else $error("complementary counters not initialised");

    crest_turn_a: assert property (
        s_crestReached |=> stateReg.countDown
            && stateReg.ch4Counter == $past(stateReg.ch4Counter) - CNT_ONE)
        else $error("no turn down at crest");

    trough_turn_a: assert property (
        s_troughReached |=> !stateReg.countDown
            && stateReg.phaseCompare == $past(stateReg.phaseTemp))
        else $error("no turn up or transfer at trough");

    entry_load_a: assert property (
        enterCompl && !cpuReq.writeEn
        |=> stateReg.phaseCompare == $past(stateReg.phaseBuffer)
            && stateReg.cycleData == $past(stateReg.cycleBuffer))
        else $error("buffers not loaded on mode entry");

    protect_read_a: assert property (
        isProtected(cpuReq.sel) && !accessEnableBit |=> cpuRdData == CNT_ZERO)
        else $error("protected register readable while blocked");

    toggle_oe_a: assert property (
        !(complMode && periodToggleEn) |-> !periodToggleOe)
        else $error("period toggle pin driven when not enabled");

    // Register access: protection, write priority, buffers, read-only counter
    protect_write_a: assert property (
        cpuReq.writeEn && !accessEnableBit && cpuReq.sel == TPM_SEL_DEAD
        |=> stateReg.deadTimeData == $past(stateReg.deadTimeData))
        else $error("blocked write changed dead time");

    cpu_wins_a: assert property (
        cpuReq.writeEn && accessEnableBit && cpuReq.sel == TPM_SEL_CH3_CNT
        |=> stateReg.ch3Counter == $past(cpuReq.data))
        else $error("counter write lost");

    buffer_write_a: assert property (
        cpuReq.writeEn && cpuReq.sel == TPM_SEL_PH1_BUF
        |=> stateReg.phaseBuffer[0] == $past(cpuReq.data))
        else $error("buffer write lost");

    sub_readonly_a: assert property (
        cpuReq.writeEn && cpuReq.sel == TPM_SEL_SUB && !complRun
        |=> stateReg.deadTimeSubcounter == $past(stateReg.deadTimeSubcounter))
        else $error("subcounter changed by a write");

    ////////////////////////////////////////////////////////////////////////////
    // Buffer chain and period pin
    sequence s_periodTurn;
        crestTurn || troughTurn;
    endsequence

    temp_freeze_a: assert property (
        complMode && (crestWindow || troughWindow) && !enterCompl
        |=> stateReg.phaseTemp == $past(stateReg.phaseTemp))
        else $error("temporary changed inside window");

    trough_limit_a: assert property (
        s_troughReached |=> stateReg.ch3UpperLimit == $past(stateReg.upperLimitBuffer)
            && stateReg.cycleData == $past(stateReg.cycleBuffer))
        else $error("limits not reloaded at trough");

    period_flip_a: assert property (
        s_periodTurn |=> periodTogglePin != $past(periodTogglePin))
        else $error("period pin missed a turn");

endmodule
`default_nettype wire

//--- dv/tpm_gate_driver_model.sv
// Gate driver model of the inverter legs: counts shoot-through of any leg
`timescale 1ns/1ps
`default_nettype none
module tpm_gate_driver_model
    import tpm_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire tpm_pwm_pins_t pins,
    input  wire logic          oe,
    input  wire logic          posLevel,
    input  wire logic          negLevel,
    output int                 overlapCnt
);
    logic [2:0] posOn;
    logic [2:0] negOn;

    assign posOn = {pins.phase1Pos, pins.phase2Pos, pins.phase3Pos} ^ {3{~posLevel}};
    assign negOn = {pins.phase1Neg, pins.phase2Neg, pins.phase3Neg} ^ {3{~negLevel}};

    initial overlapCnt = 0;

    // Both switches of one leg on together would short the supply
    always @(posedge sys_clk) begin
        if (oe && |(posOn & negOn)) begin
            overlapCnt <= overlapCnt + 1;
        end
    end
endmodule
`default_nettype wire

//--- dv/tpm_three_phase_pwm_tb.sv
// Self-checking bench for the three-phase motor PWM generator
`timescale 1ns/1ps
`default_nettype none
module tpm_three_phase_pwm_tb
    import tpm_pkg::*;
;
    logic             sys_clk;
    logic             rst;
    tpm_mode_t        modeSel;
    logic             countStart;
    logic             accessEnableBit;
    logic             posLevelSelect;
    logic             negLevelSelect;
    logic             periodToggleEn;
    tpm_cpu_req_t     cpuReq;
    logic [CNT_W-1:0] cpuRdData;
    tpm_pwm_pins_t    pwmPins;
    logic             pwmOe;
    logic             periodTogglePin;
    logic             periodToggleOe;
    int               overlapCnt;
    int               error_cnt;
    int               checks_done;

    tpm_three_phase_pwm tpm_three_phase_pwm_i (.sys_clk(sys_clk), .rst(rst), .modeSel(modeSel),
        .countStart(countStart), .accessEnableBit(accessEnableBit),
        .posLevelSelect(posLevelSelect), .negLevelSelect(negLevelSelect),
        .periodToggleEn(periodToggleEn), .cpuReq(cpuReq), .cpuRdData(cpuRdData),
        .pwmPins(pwmPins), .pwmOe(pwmOe), .periodTogglePin(periodTogglePin),
        .periodToggleOe(periodToggleOe));

    tpm_gate_driver_model tpm_gate_driver_model_i (.sys_clk(sys_clk), .pins(pwmPins), .oe(pwmOe),
        .posLevel(posLevelSelect), .negLevel(negLevelSelect), .overlapCnt(overlapCnt));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Register port: write strobe held until the caller drops it, read data one cycle after select
    task automatic wr(input tpm_reg_sel_t sel, input logic [CNT_W-1:0] data);
        cpuReq = '{1'b1, sel, data};
        @(negedge sys_clk);
    endtask

    task automatic rdchk(input tpm_reg_sel_t sel, input logic [CNT_W-1:0] exp, input string what);
        cpuReq = '{1'b0, sel, cpuReq.data};
        @(negedge sys_clk);
        check(cpuRdData, exp, what);
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        int               ul;
        int               dead;
        int               half;
        int               m3;
        int               lo;
        int               hi;
        int               flips;
        int               cmp [3];
        int               tg [3];
        logic             prevTog;
        logic [CNT_W-1:0] v;
        logic [5:0]       expPins;
        rst = 1'b1;
        modeSel = TPM_MODE_OFF;
        countStart = 1'b0;
        accessEnableBit = 1'b0;
        posLevelSelect = 1'b0;
        negLevelSelect = 1'b0;
        periodToggleEn = 1'b0;
        cpuReq = '0;
        error_cnt = 0;
        checks_done = 0;
        void'($urandom(74));
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        ////////////////////////////////////////////////////////////////////////////////
        for (int e = 0; e < 2; e++) begin
            accessEnableBit = e[0];
            for (int s = 0; s < 16; s++) begin
                v = 16'($urandom);
                wr(tpm_reg_sel_t'(s[3:0]), v);
                if (s > 12 || (e == 0 && s inside {0, 1, 2, 4, 5, 6, 10, 11})) begin
                    v = CNT_ZERO;
                end
                rdchk(tpm_reg_sel_t'(s[3:0]), v, "register readback");
            end
        end
        ////////////////////////////////////////////////////////////////////////////////
        ul = 8 + $urandom_range(7);
        cmp = '{$urandom_range(ul - 1, 1), $urandom_range(ul - 1, 1), ul};
        tg = '{0, 0, 0};
        posLevelSelect = 1'($urandom);
        negLevelSelect = 1'($urandom);
        wr(TPM_SEL_UPLIM, 16'(ul));
        wr(TPM_SEL_PH1_CMP, 16'(cmp[0]));
        wr(TPM_SEL_PH2_CMP, 16'(cmp[1]));
        wr(TPM_SEL_PH3_CMP, 16'(cmp[2]));
        wr(TPM_SEL_CH3_CNT, CNT_ZERO);
        wr(TPM_SEL_CH4_CNT, CNT_ZERO);
        cpuReq.writeEn = 1'b0;
        check(16'(pwmPins), {10'h000, {3{~posLevelSelect, ~negLevelSelect}}}, "idle pins");
        modeSel = TPM_MODE_RSYNC;
        countStart = 1'b1;
        m3 = 0;
        repeat (3 * ul + 3) begin
            @(posedge sys_clk);
            for (int p = 0; p < 3; p++) begin
                tg[p] ^= int'(m3 == cmp[p] || m3 == ul);
                expPins[5-2*p -: 2] = {posLevelSelect ^ ~tg[p][0], negLevelSelect ^ tg[p][0]};
            end
            m3 = (m3 == ul) ? 0 : m3 + 1;
            @(negedge sys_clk);
            check(16'(pwmPins), {10'h000, expPins}, "rsync pins");
            check(16'(pwmOe), CNT_ONE, "rsync enable");
        end
        ////////////////////////////////////////////////////////////////////////////////
        modeSel = TPM_MODE_OFF;
        countStart = 1'b0;
        periodToggleEn = 1'b1;
        dead = 2 + $urandom_range(2);
        half = 20 + $urandom_range(9);
        wr(TPM_SEL_DEAD, 16'(dead));
        wr(TPM_SEL_UPLIM_BUF, 16'(half + dead));
        wr(TPM_SEL_CYC_BUF, 16'(half));
        for (int p = 0; p < 3; p++) begin
            cmp[p] = $urandom_range(half - 1, dead + 1);
            wr(tpm_reg_sel_t'(4'(int'(TPM_SEL_PH1_BUF) + p)), 16'(cmp[p]));
        end
        wr(TPM_SEL_CH4_CNT, CNT_ZERO);
        cpuReq.writeEn = 1'b0;
        modeSel = TPM_MODE_COMPL;
        @(negedge sys_clk);
        rdchk(TPM_SEL_UPLIM, 16'(half + dead), "upper limit");
        rdchk(TPM_SEL_CYC, 16'(half), "cycle data");
        rdchk(TPM_SEL_PH1_CMP, 16'(cmp[0]), "compare 1");
        rdchk(TPM_SEL_PH2_CMP, 16'(cmp[1]), "compare 2");
        rdchk(TPM_SEL_PH3_CMP, 16'(cmp[2]), "compare 3");
        rdchk(TPM_SEL_CH3_CNT, 16'(dead), "ch3 start");
        rdchk(TPM_SEL_CH4_CNT, CNT_ZERO, "ch4 start");
        check(16'(periodToggleOe), CNT_ONE, "toggle enable");
        countStart = 1'b1;
        for (int k = 0; k < 2; k++) begin
            lo = 65535;
            hi = 0;
            flips = 0;
            cpuReq.sel = k ? TPM_SEL_CH4_CNT : TPM_SEL_CH3_CNT;
            @(negedge sys_clk);
            prevTog = periodTogglePin;
            repeat (5 * half) begin
                @(negedge sys_clk);
                lo = (int'(cpuRdData) < lo) ? int'(cpuRdData) : lo;
                hi = (int'(cpuRdData) > hi) ? int'(cpuRdData) : hi;
                flips += int'(periodTogglePin !== prevTog);
                prevTog = periodTogglePin;
            end
            check(16'(lo), 16'(k ? 0 : dead), "counter low");
            check(16'(hi), 16'(k ? half : half + dead), "counter high");
            check(16'(flips > 2), CNT_ONE, "period toggles");
        end
        check(16'(overlapCnt), CNT_ZERO, "leg overlap");
        report_and_stop();
    end
endmodule
`default_nettype wire
